// File: logic/ivn_pkg.sv
// constants, field layout and types for the interrupt vector number bank
package ivn_pkg;
    localparam int VEC_W = 7;
    localparam int HI_LSB = 8;
    localparam int LO_LSB = 0;
    localparam int STAT_STBY_BIT = 8;
    localparam logic [7:0] OFF_WDT_REF = 8'h00;
    localparam logic [7:0] OFF_ETHER = 8'h04;
    localparam logic [7:0] OFF_RSVD = 8'h08;
    localparam logic [7:0] OFF_FT_CC = 8'h0C;
    localparam logic [7:0] OFF_FT_OV = 8'h10;
    localparam logic [7:0] OFF_PT_AB = 8'h14;
    localparam logic [7:0] OFF_PT_CD = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1C;
    localparam logic [15:0] VCR_RESET = 16'h0000;
    localparam logic [15:0] MASK_PAIR = 16'h7F7F;
    localparam logic [15:0] MASK_HIGH = 16'h7F00;
    localparam logic [3:0] SRC_INTERVAL = 4'h0;
    localparam logic [3:0] SRC_REFRESH = 4'h1;
    localparam logic [3:0] SRC_ETHER = 4'h2;
    localparam logic [3:0] SRC_CAPTURE = 4'h3;
    localparam logic [3:0] SRC_COMPARE = 4'h4;
    localparam logic [3:0] SRC_WRAP = 4'h5;
    localparam logic [3:0] SRC_CHAN_A = 4'h6;
    localparam logic [3:0] SRC_CHAN_B = 4'h7;
    localparam logic [3:0] SRC_CHAN_C = 4'h8;
    localparam logic [3:0] SRC_CHAN_D = 4'h9;

    typedef struct packed {
        logic [15:0] watchdog_refresh_vector;
        logic [15:0] ether_dma_vector;
        logic [15:0] free_timer_capture_compare_vector;
        logic [15:0] free_timer_overflow_vector;
        logic [15:0] pulse_timer0_ab_vector;
        logic [15:0] pulse_timer0_cd_vector;
    } ivn_bank_t;

    function automatic logic [VEC_W-1:0] ivn_hi(input logic [15:0] r);
        return r[HI_LSB +: VEC_W];
    endfunction

    function automatic logic [VEC_W-1:0] ivn_lo(input logic [15:0] r);
        return r[LO_LSB +: VEC_W];
    endfunction
endpackage

// File: logic/ivn_bus_if.sv
// register access strobes between the bus front end and the bank
`timescale 1ns/1ns
interface ivn_bus_if;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [15:0] wr_data;
    logic rd_en;
    logic [7:0] rd_addr;
    modport front (output wr_en, wr_addr, wr_data, rd_en, rd_addr);
    modport bank (input wr_en, wr_addr, wr_data, rd_en, rd_addr);
endinterface

// File: logic/ivn_ahb_front.sv
// ahb-lite address/data phase tracking for the vector bank
`timescale 1ns/1ns
module ivn_ahb_front import ivn_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [15:0] hwdata,
    ivn_bus_if.front bus
);
    typedef struct packed {
        logic wr_pend;
        logic [7:0] wr_addr;
    } ivn_front_state_t;

    ivn_front_state_t s;
    ivn_front_state_t next_s;
    logic addr_ok;

    // htrans[1] covers nonseq and seq; idle and busy are ignored
    assign addr_ok = hsel && hready && htrans[1];

    always_comb begin
        next_s = s;
        next_s.wr_pend = addr_ok && hwrite;
        if (addr_ok && hwrite) begin
            next_s.wr_addr = haddr;
        end
        bus.wr_en = s.wr_pend;
        bus.wr_addr = s.wr_addr;
        bus.wr_data = hwdata;
        bus.rd_en = addr_ok && !hwrite;
        bus.rd_addr = haddr;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule

// File: logic/ivn_vec_select.sv
// picks the programmed vector number for an accepted source
`timescale 1ns/1ns
module ivn_vec_select import ivn_pkg::*; (
    input ivn_bank_t bank,
    input wire logic [3:0] src,
    output logic [VEC_W-1:0] vec,
    output logic known
);
    always_comb begin
        vec = '0;
        known = 1'b1;
        unique case (src)
            SRC_INTERVAL: vec = ivn_hi(bank.watchdog_refresh_vector);
            SRC_REFRESH: vec = ivn_lo(bank.watchdog_refresh_vector);
            SRC_ETHER: vec = ivn_hi(bank.ether_dma_vector);
            SRC_CAPTURE: vec = ivn_hi(bank.free_timer_capture_compare_vector);
            SRC_COMPARE: vec = ivn_lo(bank.free_timer_capture_compare_vector);
            SRC_WRAP: vec = ivn_hi(bank.free_timer_overflow_vector);
            SRC_CHAN_A: vec = ivn_hi(bank.pulse_timer0_ab_vector);
            SRC_CHAN_B: vec = ivn_lo(bank.pulse_timer0_ab_vector);
            SRC_CHAN_C: vec = ivn_hi(bank.pulse_timer0_cd_vector);
            SRC_CHAN_D: vec = ivn_lo(bank.pulse_timer0_cd_vector);
            default: begin
                known = 1'b0;
            end
        endcase
    end
endmodule

// File: logic/ivn_vector_regs.sv
// interrupt vector number register bank with ahb-lite slave port
//
// Operation
// - each vector field is seven bits, values 0 to 127 read back unchanged
// - reset loads every vector register with all zeros
// - standby entry or exit leaves all vector registers untouched
// - reserved bits read zero; software writes zero there
// - watchdog/refresh register bits 14..8 hold interval tick vector
// - watchdog/refresh register bits 6..0 hold refresh match vector
// - ether dma register bits 14..8 hold its vector; rest reserved
// - free timer capture/compare register bits 14..8 hold capture vector
// - free timer capture/compare register bits 6..0 hold compare vector
// - free timer overflow register bits 14..8 hold wrap vector
// - pulse timer0 a/b register bits 14..8 hold channel a vector
// - pulse timer0 a/b register bits 6..0 hold channel b vector
// - pulse timer0 c/d register bits 14..8 hold channel c vector
// - pulse timer0 c/d register bits 6..0 hold channel d vector
//
// Decided for this implementation: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ns
module ivn_vector_regs import ivn_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic standby,
    input wire logic irq_ack,
    input wire logic [3:0] irq_src,
    output logic [VEC_W-1:0] vector_num,
    output logic vector_valid
);
    typedef struct packed {
        ivn_bank_t bank;
        logic stby_meta;
        logic stby_sync;
        logic [31:0] hrdata;
        logic [VEC_W-1:0] vec;
        logic vec_valid;
        logic [3:0] last_src;
        logic hreadyout;
        logic hresp;
    } ivn_top_state_t;

    ivn_top_state_t s;
    ivn_top_state_t next_s;
    ivn_bus_if bus ();
    logic [VEC_W-1:0] sel_vec;
    logic sel_known;

    ivn_ahb_front u_front (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr[7:0]),
        .htrans(htrans),
        .hwrite(hwrite),
        .hready(hready),
        .hwdata(hwdata[15:0]),
        .bus(bus.front)
    );

    ivn_vec_select u_select (
        .bank(s.bank),
        .src(irq_src),
        .vec(sel_vec),
        .known(sel_known)
    );

    // only field bits are stored, so reserved bits cannot hold a one
    function automatic ivn_bank_t write_bank(
        input ivn_bank_t b,
        input logic [7:0] addr,
        input logic [15:0] d
    );
        ivn_bank_t r;
        r = b;
        unique case (addr)
            OFF_WDT_REF: r.watchdog_refresh_vector = d & MASK_PAIR;
            OFF_ETHER: r.ether_dma_vector = d & MASK_HIGH;
            OFF_FT_CC: r.free_timer_capture_compare_vector = d & MASK_PAIR;
            OFF_FT_OV: r.free_timer_overflow_vector = d & MASK_HIGH;
            OFF_PT_AB: r.pulse_timer0_ab_vector = d & MASK_PAIR;
            OFF_PT_CD: r.pulse_timer0_cd_vector = d & MASK_PAIR;
            // reserved slot and unmapped words drop the write
            default: r = b;
        endcase
        return r;
    endfunction

    function automatic logic [15:0] read_word(
        input ivn_bank_t b,
        input logic [7:0] addr,
        input logic stby,
        input logic [3:0] src
    );
        logic [15:0] w;
        w = 16'h0000;
        unique case (addr)
            OFF_WDT_REF: w = b.watchdog_refresh_vector;
            OFF_ETHER: w = b.ether_dma_vector;
            OFF_FT_CC: w = b.free_timer_capture_compare_vector;
            OFF_FT_OV: w = b.free_timer_overflow_vector;
            OFF_PT_AB: w = b.pulse_timer0_ab_vector;
            OFF_PT_CD: w = b.pulse_timer0_cd_vector;
            OFF_STATUS: begin
                w[3:0] = src;
                w[STAT_STBY_BIT] = stby;
            end
            default: w = 16'h0000;
        endcase
        return w;
    endfunction

    always_comb begin
        next_s = s;
        next_s.hreadyout = 1'b1;
        next_s.hresp = 1'b0;
        // standby only feeds status; the bank has no path from it
        next_s.stby_meta = standby;
        next_s.stby_sync = s.stby_meta;
        if (bus.wr_en) begin
            next_s.bank = write_bank(s.bank, bus.wr_addr, bus.wr_data);
        end
        // reading the updated bank forwards a write that ends this cycle
        if (bus.rd_en) begin
            next_s.hrdata = {16'h0000,
                read_word(next_s.bank, bus.rd_addr, s.stby_sync,
                s.last_src)};
        end
        // an ack meeting a write to the same word sees the old value
        next_s.vec_valid = 1'b0;
        if (irq_ack && sel_known) begin
            next_s.vec = sel_vec;
            next_s.vec_valid = 1'b1;
            next_s.last_src = irq_src;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.hreadyout <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign hreadyout = s.hreadyout;
    assign hresp = s.hresp;
    assign hrdata = s.hrdata;
    assign vector_num = s.vec;
    assign vector_valid = s.vec_valid;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic wr_wdt;
    logic wr_eth;
    logic wr_ftcc;
    logic wr_ftov;
    logic wr_ptab;
    logic wr_ptcd;
    assign wr_wdt = bus.wr_en && bus.wr_addr == OFF_WDT_REF;
    assign wr_eth = bus.wr_en && bus.wr_addr == OFF_ETHER;
    assign wr_ftcc = bus.wr_en && bus.wr_addr == OFF_FT_CC;
    assign wr_ftov = bus.wr_en && bus.wr_addr == OFF_FT_OV;
    assign wr_ptab = bus.wr_en && bus.wr_addr == OFF_PT_AB;
    assign wr_ptcd = bus.wr_en && bus.wr_addr == OFF_PT_CD;

    property p_full_range;
        wr_ptcd && hwdata[6:0] == 7'h7F
            |=> ivn_lo(s.bank.pulse_timer0_cd_vector) == 7'h7F;
    endproperty
    a_full_range: assert property (p_full_range)
        else $error("vector field lost a bit of 127");

    property p_reset_zero;
        !$past(hresetn) |-> s.bank == '0 && hrdata == 32'h0000_0000;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("bank not zero after reset");

    property p_standby_keep;
        ($changed(s.stby_sync) && !bus.wr_en) |=> $stable(s.bank);
    endproperty
    a_standby_keep: assert property (p_standby_keep)
        else $error("standby change altered a vector register");

    property p_rsvd_zero;
        hrdata[31:16] == 16'h0000 && !hrdata[15]
            && (s.bank.ether_dma_vector & ~MASK_HIGH) == 16'h0000;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("reserved bit read as one");

    property p_wdt_hi;
        wr_wdt |=> ivn_hi(s.bank.watchdog_refresh_vector)
            == $past(hwdata[14:8]);
    endproperty
    a_wdt_hi: assert property (p_wdt_hi)
        else $error("interval tick vector not stored");

    property p_wdt_lo;
        wr_wdt |=> ivn_lo(s.bank.watchdog_refresh_vector)
            == $past(hwdata[6:0]) && !s.bank.watchdog_refresh_vector[7];
    endproperty
    a_wdt_lo: assert property (p_wdt_lo)
        else $error("refresh match vector not stored");

    property p_ether;
        wr_eth |=> s.bank.ether_dma_vector
            == {1'b0, $past(hwdata[14:8]), 8'h00};
    endproperty
    a_ether: assert property (p_ether)
        else $error("ether dma vector wrong");

    property p_capture;
        wr_ftcc |=> ivn_hi(s.bank.free_timer_capture_compare_vector)
            == $past(hwdata[14:8]);
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture vector not stored");

    sequence s_compare_ack;
        irq_ack && irq_src == SRC_COMPARE;
    endsequence
    property p_compare;
        s_compare_ack |=> vector_valid && vector_num
            == $past(s.bank.free_timer_capture_compare_vector[6:0]);
    endproperty
    a_compare: assert property (p_compare)
        else $error("compare vector not presented");

    property p_wrap;
        wr_ftov |=> s.bank.free_timer_overflow_vector[7:0] == 8'h00
            && ivn_hi(s.bank.free_timer_overflow_vector)
            == $past(hwdata[14:8]);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("wrap vector wrong");

    property p_chan_a;
        wr_ptab ##1 (irq_ack && irq_src == SRC_CHAN_A && !bus.wr_en)
            |=> vector_num == $past(hwdata[14:8], 2);
    endproperty
    a_chan_a: assert property (p_chan_a)
        else $error("channel a vector not presented");

    property p_chan_b;
        wr_ptab |=> ivn_lo(s.bank.pulse_timer0_ab_vector)
            == $past(hwdata[6:0]);
    endproperty
    a_chan_b: assert property (p_chan_b)
        else $error("channel b vector not stored");

    property p_chan_c;
        wr_ptcd |=> ivn_hi(s.bank.pulse_timer0_cd_vector)
            == $past(hwdata[14:8]);
    endproperty
    a_chan_c: assert property (p_chan_c)
        else $error("channel c vector not stored");

    property p_chan_d;
        (irq_ack && irq_src == SRC_CHAN_D)
            |=> vector_valid && vector_num
            == $past(s.bank.pulse_timer0_cd_vector[6:0]);
    endproperty
    a_chan_d: assert property (p_chan_d)
        else $error("channel d vector not presented");

    property p_ack_pulse;
        (irq_ack && irq_src <= SRC_CHAN_D) |=> vector_valid
            ##1 (vector_valid == $past(irq_ack && irq_src <= SRC_CHAN_D));
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("vector valid not a single accepted pulse");

    property p_no_spurious;
        !(irq_ack && sel_known) |=> !vector_valid;
    endproperty
    a_no_spurious: assert property (p_no_spurious)
        else $error("vector valid without acceptance");

    property p_read_back;
        (bus.rd_en && bus.rd_addr == OFF_ETHER && !bus.wr_en)
            |=> hrdata[15:0] == $past(s.bank.ether_dma_vector);
    endproperty
    a_read_back: assert property (p_read_back)
        else $error("ether dma vector read back wrong");

    c_write_wdt: cover property (wr_wdt ##1 bus.rd_en);
    c_ack_ether: cover property (irq_ack && irq_src == SRC_ETHER);
    c_read_status: cover property (bus.rd_en && bus.rd_addr == OFF_STATUS);
    c_standby: cover property ($rose(s.stby_sync) ##[1:20] wr_ptab);
endmodule

// File: verif/tb_interrupt_vector_number_regs.sv
// self-checking bench for the interrupt vector number register bank
`timescale 1ns/1ns
module tb_interrupt_vector_number_regs;
    import ivn_pkg::*;

    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic standby = 1'b0;
    logic irq_ack = 1'b0;
    logic [3:0] irq_src = 4'h0;
    logic [VEC_W-1:0] vector_num;
    logic vector_valid;
    int fails = 0;
    int num_checks = 0;

    // expected contents, kept from what the bench wrote through the masks
    // the reserved slot at OFF_RSVD is never read or written
    logic [7:0] offs [6] = '{OFF_WDT_REF, OFF_ETHER, OFF_FT_CC, OFF_FT_OV,
        OFF_PT_AB, OFF_PT_CD};
    logic [15:0] masks [6] = '{MASK_PAIR, MASK_HIGH, MASK_PAIR, MASK_HIGH,
        MASK_PAIR, MASK_PAIR};
    logic [15:0] shadow [6] = '{default: 16'h0};
    // source code to register index and half
    int src_reg [10] = '{0, 0, 1, 2, 2, 3, 4, 4, 5, 5};
    logic src_hi [10] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0,
        1'b1, 1'b0};

    // single slave: its hreadyout is the bus hready
    ivn_vector_regs ivn_vector_regs_inst (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .standby(standby),
        .irq_ack(irq_ack),
        .irq_src(irq_src),
        .vector_num(vector_num),
        .vector_valid(vector_valid)
    );

    always #50 hclk = ~hclk;

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // the master allows wait states: it waits for hready under a 100-cycle bound
    task automatic wait_ready;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 100) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 100) begin
            fails++;
        end
    endtask

    task automatic bus_xfer(input logic wr, input logic [7:0] a,
        input logic [15:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        wait_ready;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {16'h0, d};
        wait_ready;
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] q;
        bus_xfer(1'b1, a, d, q);
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus_xfer(1'b0, a, 16'h0, q);
        check_data(q, exp);
        check_data({31'h0, hresp}, 32'h0);
    endtask

    task automatic check_all;
        for (int i = 0; i < 6; i++) begin
            rd_check(offs[i], {16'h0, shadow[i]});
        end
    endtask

    // ack is taken at the next edge; the answer stands for one cycle
    task automatic ack_check(input logic [3:0] s, input logic exp_valid,
        input logic [6:0] exp_num);
        irq_ack <= 1'b1;
        irq_src <= s;
        @(posedge hclk);
        irq_ack <= 1'b0;
        #1;
        check_data({31'h0, vector_valid}, {31'h0, exp_valid});
        if (exp_valid) begin
            check_data({25'h0, vector_num}, {25'h0, exp_num});
        end
        @(posedge hclk);
        #1;
        check_data({31'h0, vector_valid}, 32'h0);
        @(posedge hclk);
    endtask

    initial begin
        repeat (5000) @(posedge hclk);
        fails++;
        end_of_test;
    end

    initial begin
        logic [15:0] d;
        logic [6:0] e;
        int r;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check_all;
        // unmapped word: write dropped, read gives zero
        wr(8'h20, 16'hFFFF);
        rd_check(8'h20, 32'h0);
        // all ones in every field: widest value, reserved bits written zero
        for (int i = 0; i < 6; i++) begin
            wr(offs[i], 16'hFFFF & masks[i]);
            shadow[i] = 16'hFFFF & masks[i];
            rd_check(offs[i], {16'h0, shadow[i]});
        end
        // distinct patterns, read straight after the write
        for (int i = 0; i < 6; i++) begin
            d = 16'h9B35 + 16'(i) * 16'h1111;
            wr(offs[i], d & masks[i]);
            shadow[i] = d & masks[i];
            rd_check(offs[i], {16'h0, shadow[i]});
        end
        check_all;
        // ack straight after a write presents the new vector
        wr(OFF_PT_AB, 16'h2A55);
        shadow[4] = 16'h2A55;
        ack_check(SRC_CHAN_A, 1'b1, 7'h2A);
        for (int s = 0; s < 10; s++) begin
            r = src_reg[s];
            e = src_hi[s] ? shadow[r][14:8] : shadow[r][6:0];
            ack_check(4'(s), 1'b1, e);
        end
        // codes past the last source give no answer
        for (int s = 10; s < 16; s++) begin
            ack_check(4'(s), 1'b0, 7'h0);
        end
        standby <= 1'b1;
        repeat (6) @(posedge hclk);
        check_all;
        rd_check(OFF_STATUS, 32'(1 << STAT_STBY_BIT) | 32'(SRC_CHAN_D));
        standby <= 1'b0;
        repeat (6) @(posedge hclk);
        check_all;
        rd_check(OFF_STATUS, 32'(SRC_CHAN_D));
        // second reset in mid-run clears the bank again
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        shadow = '{default: 16'h0};
        check_all;
        rd_check(OFF_STATUS, 32'h0);
        ack_check(SRC_CHAN_D, 1'b1, 7'h0);
        end_of_test;
    end
endmodule
